// ---- logic/fault_status_history_log.sv ----
/*
  Fault status and history log of a six-channel supervisor: live fault
  word, latched log with clear, one-shot nonvolatile snapshot, store and
  restore, alert. Commands come as decoded command bytes from the serial
  slave in front; comparator and pin inputs are asynchronous.
  // How it works
  // - Command 11h reads latched log, updated on faults
  // - Command 1Bh clears log, live word untouched
  // - Enabled manual reset clears log like 1Bh
  // - No acknowledge while clear is processing
  // - Log: channel pairs bits 1..12, rest reserved
  // - 1Ch stores, 1Dh and power-up restore
  // - First fault backs up log, then inhibited
  // - Snapshot uses log bit positions
  // - Command 1Fh reads live comparator word
  // - Margin or UV-ignore inputs suppress live bits
  // - Polarity 1 faults above, 0 below
  // - Margin masks all, UV-ignore masks UV only
  // - Log read or clear drops idle alert
  // - Commands ignored during nonvolatile transactions
*/
`timescale 1ns/10ps
`default_nettype none

module fault_status_history_log
  import fault_log_pkg::*;
#(
  parameter int CH_N        = `CH_N,
  parameter int CLEAR_CYCLES =
    `CLEAR_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS,
  parameter int NVM_WR_CYC  = `NVM_WR_CYCLES,
  parameter int NVM_RD_CYC  = `NVM_RD_CYCLES
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Decoded command bytes
  input  wire logic                cmd_valid_i,
  input  wire logic [7:0]          cmd_code_i,
  // Answers
  output logic                     cmd_ack_o,
  output logic                     cmd_nack_o,
  output logic                     rd_valid_o,
  output fault_word_t              rd_data_o,
  output logic                     alert_o,
  // Comparators, asynchronous: 1 means input above threshold
  input  wire logic [CH_N-1:0]     hi_above_thr_i,
  input  wire logic [CH_N-1:0]     lo_above_thr_i,
  // Configuration, same clock
  input  wire logic [CH_N-1:0]     high_comparator_polarity_i,
  input  wire logic [CH_N-1:0]     low_comparator_polarity_i,
  input  wire logic [`FUNC_W-1:0]  general_input_function_select_0_i,
  input  wire logic [`FUNC_W-1:0]  general_input_function_select_1_i,
  input  wire logic                manual_reset_log_clear_enable_i,
  // Pins, asynchronous, active low
  input  wire logic [1:0]          general_input_pin_n_i,
  input  wire logic                manual_reset_input_n_i
);

  // ========================================================================
  // Input synchronisers
  localparam int AN = 3 + 2 * CH_N;

  logic [AN-1:0] async_in;   // Raw asynchronous inputs
  logic [AN-1:0] s1_ff;      // First stage, read only by s2
  logic [AN-1:0] s2_ff;      // Second stage
  logic [AN-1:0] s3_ff;      // Third stage
  logic [AN-1:0] filt_ff;    // Accepted once s2 and s3 agree

  assign async_in = {manual_reset_input_n_i, general_input_pin_n_i,
                     hi_above_thr_i, lo_above_thr_i};

  // One three-stage chain per input bit
  for (genvar b = 0; b < AN; b++) begin : g_sync
    // Pins start at their released level so no false edge follows reset
    localparam logic IDLE = (b >= 2 * CH_N);
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        s1_ff[b]   <= IDLE;
        s2_ff[b]   <= IDLE;
        s3_ff[b]   <= IDLE;
        filt_ff[b] <= IDLE;
      end else begin
        s1_ff[b] <= async_in[b];
        s2_ff[b] <= s1_ff[b];
        s3_ff[b] <= s2_ff[b];
        // Agreement filter drops single-cycle glitches
        if (s2_ff[b] == s3_ff[b]) begin
          filt_ff[b] <= s3_ff[b];
        end
      end
    end
  end

  logic [CH_N-1:0] hi_above;  // Filtered high comparator
  logic [CH_N-1:0] lo_above;  // Filtered low comparator
  logic [1:0]      gpi_on;    // General inputs asserted
  logic            mr_on;     // Manual reset asserted

  assign lo_above = filt_ff[CH_N-1:0];
  assign hi_above = filt_ff[2*CH_N-1:CH_N];
  assign gpi_on   = ~filt_ff[2*CH_N+1:2*CH_N];
  assign mr_on    = ~filt_ff[AN-1];

  // ========================================================================
  // Live fault word
  logic        margin_on;  // Trim mask active
  logic        uv_ign_on;  // Undervoltage mask active
  fault_word_t live_nxt;   // Masked comparator word
  fault_word_t live_ff;    // Live fault state

  // Either general input may carry either function
  assign margin_on =
    (gpi_on[0] && general_input_function_select_0_i == `FUNC_MARGIN) ||
    (gpi_on[1] && general_input_function_select_1_i == `FUNC_MARGIN);
  assign uv_ign_on =
    (gpi_on[0] && general_input_function_select_0_i == `FUNC_UV_IGNORE) ||
    (gpi_on[1] && general_input_function_select_1_i == `FUNC_UV_IGNORE);

  always_comb begin
    live_nxt = `FAULT_ZERO;
    for (int c = 0; c < CH_N; c++) begin
      // Polarity 1 is an overvoltage check, 0 an undervoltage one
      live_nxt[`LO_BASE_BIT + 2*c] =
        (low_comparator_polarity_i[c] ? lo_above[c] : !lo_above[c])
        && !margin_on && !(uv_ign_on && !low_comparator_polarity_i[c]);
      live_nxt[`HI_BASE_BIT + 2*c] =
        (high_comparator_polarity_i[c] ? hi_above[c] : !hi_above[c])
        && !margin_on && !(uv_ign_on && !high_comparator_polarity_i[c]);
    end
  end

  logic [2:0] warm_ff;  // Cycles since reset, saturates once the pipe is full

  // Pipe fill counter; comparators are not trusted before it saturates
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      warm_ff <= 3'h0;
    end else if (warm_ff != 3'h4) begin
      warm_ff <= warm_ff + 3'h1;
    end
  end

  // Snapshot of comparators every cycle, reserved bits forced low;
  // held at zero while the pipe fills so reset values latch no fault
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      live_ff <= `FAULT_ZERO;
    end else if (warm_ff != 3'h4) begin
      live_ff <= `FAULT_ZERO;
    end else begin
      live_ff <= live_nxt & ~`RSV_MASK;
    end
  end

  // ========================================================================
  // Command decode and busy window
  localparam int CW = $clog2(CLEAR_CYCLES + 1);

  logic          nvm_busy;     // Store or restore transaction running
  logic          rst_pend_ff;  // Power-up restore still owed
  logic          bk_pend_ff;   // Backup write still owed
  logic [CW-1:0] clr_cnt_ff;   // Cycles of clear processing left
  logic          busy;         // Any reason to refuse a known command
  logic          acc;          // Command taken this cycle
  logic          known;        // Command belongs to this block
  logic          acc_clr;      // Log clear taken
  logic          mr_prev_ff;   // Manual reset last cycle
  logic          mr_clr;       // Enabled manual reset edge
  logic          do_clear;     // Any log clear

  // Read-done cycle counts as busy: the snapshot lands one edge later
  assign busy    = (clr_cnt_ff != '0) || nvm_busy || rst_pend_ff
                   || bk_pend_ff || nvm_done;
  assign known   = cmd_code_i inside {`CMD_LOG_READ, `CMD_LOG_CLEAR,
                   `CMD_NVM_STORE, `CMD_NVM_RESTORE, `CMD_SNAP_READ,
                   `CMD_LIVE_READ};
  assign acc     = cmd_valid_i && !busy && known;
  assign acc_clr = acc && cmd_code_i == `CMD_LOG_CLEAR;
  assign mr_clr  = mr_on && !mr_prev_ff && manual_reset_log_clear_enable_i;
  assign do_clear = acc_clr || mr_clr;

  // Clear processing window; this block refuses commands meanwhile
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      clr_cnt_ff <= '0;
      mr_prev_ff <= 1'b0;
    end else begin
      mr_prev_ff <= mr_on;
      if (acc_clr) begin
        clr_cnt_ff <= CW'(CLEAR_CYCLES);
      end else if (clr_cnt_ff != '0) begin
        clr_cnt_ff <= clr_cnt_ff - 1'b1;
      end
    end
  end

  // ========================================================================
  // Latched log; a fault in the clear cycle survives the clear
  fault_word_t log_ff;  // Latched fault log

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      log_ff <= `FAULT_ZERO;
    end else begin
      log_ff <= (do_clear ? `FAULT_ZERO : log_ff) | live_ff;
    end
  end

  // ========================================================================
  // Nonvolatile backup, store and restore
  logic        first_flt;  // First fault since clear
  logic        inhib_ff;   // Later backups inhibited
  logic        nvm_wr;     // Write request
  logic        nvm_rd;     // Read request
  logic        nvm_done;   // Read finished
  fault_word_t nvm_word;   // Word read back
  fault_word_t snap_ff;    // Snapshot in operating memory

  assign first_flt = (log_ff == `FAULT_ZERO) && (live_ff != `FAULT_ZERO)
                     && !inhib_ff;
  assign nvm_rd = !nvm_busy && (rst_pend_ff ||
                  (acc && cmd_code_i == `CMD_NVM_RESTORE));
  assign nvm_wr = !nvm_busy && !rst_pend_ff && (bk_pend_ff ||
                  (acc && cmd_code_i == `CMD_NVM_STORE));

  // Backup arms once, re-armed only by a clear; set wins over clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      inhib_ff    <= 1'b0;
      bk_pend_ff  <= 1'b0;
      rst_pend_ff <= 1'b1;
    end else begin
      inhib_ff    <= first_flt || (inhib_ff && !do_clear);
      bk_pend_ff  <= first_flt || (bk_pend_ff && !nvm_wr);
      rst_pend_ff <= rst_pend_ff && !nvm_rd;
    end
  end

  // Writes carry the latched log, so clear then store erases the copy
  fault_log_nvm #(
    .WR_CYCLES (NVM_WR_CYC),
    .RD_CYCLES (NVM_RD_CYC)
  ) u_nvm (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_req_i  (nvm_wr),
    .wr_data_i (log_ff),
    .rd_req_i  (nvm_rd),
    .busy_o    (nvm_busy),
    .rd_done_o (nvm_done),
    .rd_data_o (nvm_word)
  );

  // Restored word lands in operating memory, same layout as the log
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      snap_ff <= `FAULT_ZERO;
    end else if (nvm_done) begin
      snap_ff <= nvm_word & ~`RSV_MASK;
    end
  end

  // ========================================================================
  // Answers to the serial slave
  fault_word_t rd_sel;  // Word chosen by the command

  always_comb begin
    rd_sel = `FAULT_ZERO;
    unique case (cmd_code_i)
      `CMD_LOG_READ:  rd_sel = log_ff;
      `CMD_SNAP_READ: rd_sel = snap_ff;
      `CMD_LIVE_READ: rd_sel = live_ff;
      default:        rd_sel = `FAULT_ZERO;
    endcase
  end

  // One answer per command, one cycle after it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_ack_o  <= 1'b0;
      cmd_nack_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= `FAULT_ZERO;
    end else begin
      cmd_ack_o  <= acc;
      cmd_nack_o <= cmd_valid_i && !acc;
      rd_valid_o <= acc && (rd_sel != `FAULT_ZERO || cmd_code_i inside
                    {`CMD_LOG_READ, `CMD_SNAP_READ, `CMD_LIVE_READ});
      if (acc) begin
        rd_data_o <= rd_sel & ~`RSV_MASK;
      end
    end
  end

  // Alert: new fault sets; log read or clear drops it unless faults persist
  logic alert_clr;  // Host has serviced the log

  assign alert_clr = do_clear || (acc && cmd_code_i == `CMD_LOG_READ);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      alert_o <= 1'b0;
    end else begin
      alert_o <= ((live_ff & ~log_ff) != `FAULT_ZERO)
                 || (alert_o && !(alert_clr && live_ff == `FAULT_ZERO));
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_log_read;
    acc && cmd_code_i == `CMD_LOG_READ |=>
      rd_valid_o && rd_data_o == $past(log_ff);
  endproperty
  a_log_read: assert property (p_log_read) else $error("log read wrong");

  property p_clear_cmd;
    acc_clr |=> log_ff == $past(live_ff);
  endproperty
  a_clear_cmd: assert property (p_clear_cmd) else $error("clear failed");

  property p_mr_clear;
    mr_clr && !acc_clr |=> log_ff == $past(live_ff);
  endproperty
  a_mr_clear: assert property (p_mr_clear) else $error("mr clear failed");

  property p_clear_nack;
    acc_clr ##1 cmd_valid_i |=> cmd_nack_o && !cmd_ack_o;
  endproperty
  a_clear_nack: assert property (p_clear_nack) else $error("ack in clear");

  property p_rsv_zero;
    rd_valid_o |-> (rd_data_o & `RSV_MASK) == `FAULT_ZERO;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved set");

  property p_restore;
    nvm_done |=> snap_ff == $past(nvm_word & ~`RSV_MASK);
  endproperty
  a_restore: assert property (p_restore) else $error("restore lost");

  property p_backup_once;
    first_flt |=> inhib_ff && bk_pend_ff && (nvm_wr || nvm_busy);
  endproperty
  a_backup_once: assert property (p_backup_once) else $error("no backup");

  property p_margin;
    margin_on |=> live_ff == `FAULT_ZERO;
  endproperty
  a_margin: assert property (p_margin) else $error("margin leak");

  property p_nvm_ignore;
    nvm_busy && cmd_valid_i |=> cmd_nack_o;
  endproperty
  a_nvm_ignore: assert property (p_nvm_ignore) else $error("cmd in nvm");

  property p_alert_drop;
    alert_clr && live_ff == `FAULT_ZERO |=> !alert_o;
  endproperty
  a_alert_drop: assert property (p_alert_drop) else $error("alert stuck");

  c_clear:   cover property (acc_clr);
  c_backup:  cover property (first_flt ##[1:40] nvm_wr);
  c_restore: cover property (nvm_done && snap_ff != `FAULT_ZERO);

endmodule : fault_status_history_log

`default_nettype wire

// ---- logic/fault_log_consts.svh ----
/*
  Constants of the fault status and history log: command codes, field
  layout, function codes of the general inputs and timing figures.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef FAULT_LOG_CONSTS_SVH
`define FAULT_LOG_CONSTS_SVH

// ==========================================================================
// Command bytes
`define CMD_LOG_READ     8'h11
`define CMD_LOG_CLEAR    8'h1B
`define CMD_NVM_STORE    8'h1C
`define CMD_NVM_RESTORE  8'h1D
`define CMD_SNAP_READ    8'h1E
`define CMD_LIVE_READ    8'h1F

// ==========================================================================
// Fault word layout: channel c low at 2c+1, high at 2c+2
`define FAULT_W          16
`define CH_N             6
`define LO_BASE_BIT      1
`define HI_BASE_BIT      2
`define RSV_MASK         16'hE001
`define FAULT_ZERO       16'h0000

// ==========================================================================
// General input function codes
`define FUNC_W           3
`define FUNC_MARGIN      3'h2
`define FUNC_UV_IGNORE   3'h3

// ==========================================================================
// Timing
`define CLK_PERIOD_NS    10
`define CLEAR_TIME_MS    10
`define NS_PER_MS        1000000
`define NVM_WR_CYCLES    16
`define NVM_RD_CYCLES    16
`define NVM_CNT_W        16

`endif

// ---- logic/fault_log_pkg.sv ----
/*
  Types shared by the fault log and its nonvolatile store.
  Assumes fault_log_consts.svh is on the include path.
*/
`include "fault_log_consts.svh"

package fault_log_pkg;

  // One fault word
  typedef logic [`FAULT_W-1:0] fault_word_t;

  // Nonvolatile store sequencer, Gray along idle to write
  typedef enum logic [1:0] {
    NVM_IDLE  = 2'b00,
    NVM_WRITE = 2'b01,
    NVM_READ  = 2'b11
  } nvm_state_t;

endpackage : fault_log_pkg

// ---- logic/fault_log_nvm.sv ----
/*
  Nonvolatile backup word with timed write and read transactions.
  Assumes requests arrive only while busy_o is low.
*/
`timescale 1ns/10ps
`default_nettype none

module fault_log_nvm
  import fault_log_pkg::*;
#(
  parameter int WR_CYCLES = `NVM_WR_CYCLES,
  parameter int RD_CYCLES = `NVM_RD_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Requests
  input  wire logic        wr_req_i,
  input  wire fault_word_t wr_data_i,
  input  wire logic        rd_req_i,
  // Status and answer
  output logic             busy_o,
  output logic             rd_done_o,
  output fault_word_t      rd_data_o
);

  // ========================================================================
  // Storage and sequencer
  nvm_state_t               state_ff;  // Transaction in flight
  logic [`NVM_CNT_W-1:0]    cnt_ff;    // Cycles left in transaction
  fault_word_t              data_ff;   // Word waiting to be written
  fault_word_t              cell_ff;   // The nonvolatile cell itself
  logic                     done_ff;   // Read finished pulse
  logic                     last;      // Final cycle of transaction

  assign last      = (cnt_ff == `NVM_CNT_W'(0));
  assign busy_o    = (state_ff != NVM_IDLE);
  assign rd_done_o = done_ff;
  assign rd_data_o = cell_ff;

  // Sequencer; reset stands for the first power-up of an erased array
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= NVM_IDLE;
      cnt_ff   <= '0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        NVM_IDLE: begin
          if (rd_req_i) begin
            state_ff <= NVM_READ;
            cnt_ff   <= `NVM_CNT_W'(RD_CYCLES - 1);
          end else if (wr_req_i) begin
            state_ff <= NVM_WRITE;
            cnt_ff   <= `NVM_CNT_W'(WR_CYCLES - 1);
          end
        end
        NVM_WRITE, NVM_READ: begin
          cnt_ff <= cnt_ff - 1'b1;
          if (last) begin
            done_ff  <= (state_ff == NVM_READ);
            state_ff <= NVM_IDLE;
          end
        end
        default: state_ff <= NVM_IDLE;
      endcase
    end
  end

  // Pending data and the cell; the cell changes only at the end of a write
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_ff <= `FAULT_ZERO;
      cell_ff <= `FAULT_ZERO;
    end else begin
      if (state_ff == NVM_IDLE && wr_req_i && !rd_req_i) begin
        data_ff <= wr_data_i & ~`RSV_MASK;
      end
      if (state_ff == NVM_WRITE && last) begin
        cell_ff <= data_ff;
      end
    end
  end

endmodule : fault_log_nvm

`default_nettype wire

// ---- dv/cmd_host_model.sv ----
/*
  Host side of the decoded command port: issues one command byte at a
  time and retries while the log refuses it.
  Assumes the command and answer timing of the fault status log.
*/
`timescale 1ns/10ps
`default_nettype none

module cmd_host_model
  import fault_log_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Answers from the log
  input  wire logic        cmd_ack_i,
  input  wire logic        cmd_nack_i,
  input  wire logic        rd_valid_i,
  input  wire fault_word_t rd_data_i,
  // Command port
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o
);
  // ==========================================================================
  // Idle port
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 8'h00;
  end

  // ==========================================================================
  // One command: pulse for one edge, answer sampled while it stands.
  // Tries bounds the retry so a device that never answers shows up.
  task automatic send(input logic [7:0] code, input int tries,
                      output logic [1:0] ans, output logic got_rd,
                      output fault_word_t data);
    int n;
    n      = 0;
    ans    = 2'b00;
    got_rd = 1'b0;
    data   = 16'h0000;
    while (ans !== 2'b01 && n < tries) begin
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o  = code;
      @(negedge clk_i);
      // Answer is registered on the edge that took the command
      ans    = {cmd_nack_i, cmd_ack_i};
      got_rd = rd_valid_i;
      data   = rd_data_i;
      cmd_valid_o = 1'b0;
      cmd_code_o  = ~code;  // Code carries no meaning outside the pulse
      n++;
    end
  endtask : send
endmodule : cmd_host_model

`default_nettype wire

// ---- dv/tb_top.sv ----
/*
  Self-checking bench of the fault status and history log.
  Assumes the design with short clear and nonvolatile timing parameters.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fault_log_consts.svh"

module tb_top
  import fault_log_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        clk_i;
  logic        sys_rst_i;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic        cmd_ack;
  logic        cmd_nack;
  logic        rd_valid;
  fault_word_t rd_data;
  logic        alert;
  logic [5:0]  hi_above;     // Comparator outputs, 1 = above threshold
  logic [5:0]  lo_above;
  logic [5:0]  hi_pol;
  logic [5:0]  lo_pol;
  logic [2:0]  fsel0;
  logic [2:0]  fsel1;
  logic        mr_en;
  logic [1:0]  general_input_pin_n;
  logic        mr_n;
  int          fails;
  int          compares;
  int          cycles;

  // ==========================================================================
  // Design, short windows keep the run brief
  fault_status_history_log #(
    .CH_N(6), .CLEAR_CYCLES(8), .NVM_WR_CYC(4), .NVM_RD_CYC(4)
  ) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
    .cmd_ack_o(cmd_ack), .cmd_nack_o(cmd_nack),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .alert_o(alert),
    .hi_above_thr_i(hi_above), .lo_above_thr_i(lo_above),
    .high_comparator_polarity_i(hi_pol), .low_comparator_polarity_i(lo_pol),
    .general_input_function_select_0_i(fsel0),
    .general_input_function_select_1_i(fsel1),
    .manual_reset_log_clear_enable_i(mr_en),
    .general_input_pin_n_i(general_input_pin_n), .manual_reset_input_n_i(mr_n)
  );

  // Host partner
  cmd_host_model host (
    .clk_i(clk_i), .cmd_ack_i(cmd_ack), .cmd_nack_i(cmd_nack),
    .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code)
  );

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Ceiling well above the few hundred cycles the tests need
  initial cycles = 0;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      $display("CHECK FAILED at %0t: cycle ceiling reached", $time);
      wrap_up();
    end
  end

  // ==========================================================================
  // Helpers
  // Expected fault bit: low of channel c at 2c+1, high at 2c+2
  function automatic fault_word_t fb(input int c, input int hi);
    fb = 16'h0001 << (2 * c + 1 + hi);
  endfunction : fb

  task automatic check(input fault_word_t got, input fault_word_t exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Command whose answer is known: 01 taken, 10 refused
  task automatic cmd(input logic [7:0] code, input logic [1:0] exp, input int tries);
    logic [1:0]  a;
    logic        v;
    fault_word_t d;
    host.send(code, tries, a, v, d);
    check({14'h0000, a}, {14'h0000, exp}, "command answer");
  endtask : cmd

  // Read with retries through refusal windows
  task automatic rd(input logic [7:0] code, input fault_word_t exp);
    logic [1:0]  a;
    logic        v;
    fault_word_t d;
    host.send(code, 40, a, v, d);
    check({14'h0000, a}, 16'h0001, "read taken");
    check({15'h0000, v}, 16'h0001, "read valid");
    check(d, exp, "read word");
  endtask : rd

  // Inputs pass a sync pipe of about five cycles
  task automatic settle();
    repeat (8) @(negedge clk_i);
  endtask : settle

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Main sequence
  initial begin
    fails     = 0;
    compares  = 0;
    sys_rst_i = 1'b1;
    hi_above  = 6'h00;  // No channel over its high threshold
    lo_above  = 6'h3F;  // All channels above their low threshold
    hi_pol    = 6'h3F;
    lo_pol    = 6'h00;
    fsel0     = 3'h0;
    fsel1     = 3'h0;
    mr_en     = 1'b0;
    general_input_pin_n    = 2'h3;
    mr_n      = 1'b1;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    // Power-up restore window and sync pipe fill
    repeat (26) @(negedge clk_i);
    rd(`CMD_LIVE_READ, 16'h0000);
    rd(`CMD_LOG_READ, 16'h0000);
    cmd(8'h55, 2'b10, 1);  // Unknown code refused
    done("idle");
    // A fault latches, raises alert and takes the one-shot backup
    hi_above[0] = 1'b1;
    settle();
    rd(`CMD_LIVE_READ, fb(0, 1));
    check({15'h0000, alert}, 16'h0001, "alert raised");
    hi_above[0] = 1'b0;
    settle();
    rd(`CMD_LIVE_READ, 16'h0000);
    rd(`CMD_LOG_READ, fb(0, 1));
    @(negedge clk_i);
    check({15'h0000, alert}, 16'h0000, "alert dropped");
    lo_above[5] = 1'b0;
    settle();
    rd(`CMD_LOG_READ, fb(0, 1) | fb(5, 0));
    lo_above[5] = 1'b1;
    settle();
    cmd(`CMD_NVM_RESTORE, 2'b01, 40);
    rd(`CMD_SNAP_READ, fb(0, 1));
    done("latch_backup");
    // Clear, refusal window, then erase of the snapshot
    cmd(`CMD_LOG_CLEAR, 2'b01, 40);
    cmd(`CMD_LIVE_READ, 2'b10, 1);
    rd(`CMD_LOG_READ, 16'h0000);
    rd(`CMD_LIVE_READ, 16'h0000);
    cmd(`CMD_NVM_STORE, 2'b01, 40);
    cmd(`CMD_LOG_READ, 2'b10, 1);
    cmd(`CMD_NVM_RESTORE, 2'b01, 40);
    rd(`CMD_SNAP_READ, 16'h0000);
    done("clear_store");
    // Polarity and masking by the general inputs
    hi_pol[2] = 1'b0;  // Channel 2 high becomes undervoltage type
    lo_pol[3] = 1'b1;  // Channel 3 low becomes overvoltage type
    settle();
    rd(`CMD_LIVE_READ, fb(2, 1) | fb(3, 0));
    fsel0     = `FUNC_MARGIN;
    general_input_pin_n[0] = 1'b0;
    settle();
    rd(`CMD_LIVE_READ, 16'h0000);
    general_input_pin_n[0] = 1'b1;
    fsel1     = `FUNC_UV_IGNORE;
    general_input_pin_n[1] = 1'b0;
    settle();
    rd(`CMD_LIVE_READ, fb(3, 0));
    general_input_pin_n[1] = 1'b1;
    hi_pol    = 6'h3F;
    lo_pol    = 6'h00;
    settle();
    rd(`CMD_LIVE_READ, 16'h0000);
    rd(`CMD_LOG_READ, fb(2, 1) | fb(3, 0));
    done("polarity_mask");
    // Enabled manual reset clears the log left by the polarity test
    mr_en = 1'b1;
    mr_n  = 1'b0;
    settle();
    mr_n = 1'b1;
    settle();
    rd(`CMD_LOG_READ, 16'h0000);
    done("manual_reset");
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
